// *** kms_pkg.sv ***
// Shared constants, register offsets and field layout of the keyboard matrix scanner.
package kms_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int KBD_PHASE_NS  = 1400;
    localparam int IO_PHASE_NS   = 4300;
    localparam int KEY_VALID_NS  = 1200;
    localparam int SW_VALID_NS   = 4000;
    localparam int ADC_TRACK_NS  = 1000;
    localparam int ADC_HOLD_NS   = 2200;

    localparam logic [8:0] KBD_PHASE_CYC = 9'((KBD_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0] IO_PHASE_CYC  = 9'((IO_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0] ROW_SLOT_CYC  = 9'(KBD_PHASE_CYC + IO_PHASE_CYC);
    localparam logic [8:0] KEY_SAMPLE_AT = 9'((KEY_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0] SW_SAMPLE_AT  =
        9'(KBD_PHASE_CYC + (SW_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0] ADC_TRACK_AT  = 9'((ADC_TRACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0] ADC_HOLD_AT   = 9'(ADC_HOLD_NS / CLK_PERIOD_NS);

    localparam logic [3:0] ADDR_SETUP  = 4'hb;
    localparam logic [3:0] ADDR_STATUS = 4'hc;
    localparam logic [3:0] ADDR_DLOW   = 4'hd;
    localparam logic [3:0] ADDR_DHIGH  = 4'he;

    localparam logic [6:0] KEY_LAST = 7'h57;
    localparam logic [6:0] LED_BASE = 7'h58;
    localparam logic [6:0] SW_BASE  = 7'h60;
    localparam logic [6:0] ADC_BASE = 7'h70;

    localparam int NUM_COLS  = 11;
    localparam int NUM_KEYS  = 88;
    localparam int RAM_WORDS = 128;

    localparam int SRQ_BIT        = 10;
    localparam int ON_BIT         = 9;
    localparam int BUSY_BIT       = 8;
    localparam int REQ_STATUS_BIT = 7;
    localparam int CFG_SPRING_BIT = 0;
    localparam int CFG_CATH_BIT   = 1;

    localparam logic [1:0] CFG_RESET = 2'h0;
    localparam logic [7:0] TIME_MAX  = 8'hff;
    localparam logic [7:0] TIME_ZERO = 8'h00;

    typedef enum logic {PH_KEYS, PH_IO} kms_phase_t;
endpackage

// *** kms_scanner.sv ***
// Keyboard matrix scanner: row sequencing, key velocity, switches, LEDs, converter store.
// Operation
// R01: Two-bit write-only setup register, reads meaningless.
// R02: Setup bit 0 picks rubber or spring contacts.
// R03: Setup bit 1 picks anode or cathode wiring.
// R04: Setup register clears to zero at reset.
// R05: Three port addresses: status/pointer, data low, high.
// R06: RAM split into keys, LEDs, switches, converter.
// R07: Status bit 7 flags pending key request.
// R08: Status bits 6:0 give requesting key number.
// R09: Status write loads RAM pointer, bit 7 ignored.
// R10: Key address is eight times column plus row.
// R11: Row select cycles 0 to 7, 45 us.
// R12: Without fourth row, upper switch/converter entries alias.
// R13: Data low is bits 7:0, high bits 10:8.
// R14: Service bit set on completion, busy then clear.
// R15: Bit 9 gives direction, 1 pressed.
// R16: Bit 8 marks measurement in progress.
// R17: Bits 7:0 count 45 us units, saturate 255.
// R18: LED entry drives make lines in row slot.
// R19: Break lines captured into switch entry per row.
// R20: Converter code stored per row in bits 7:0.
// R21: Velocity measured for both press and release.
// R22: Strobe high 1.4 us keys, low 4.3 us.
// R23: Break is first contact, make second contact.
// R24: Press and release timing start and stop order.
module kms_scanner
    import kms_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    input  wire logic        row3_used,
    output logic      [2:0]  row_sel,
    output logic             row3_out,
    output logic             scan_phase_strobe,
    output logic      [10:0] make_column_line_out,
    output logic             make_column_line_oe,
    input  wire logic [10:0] make_column_line_in,
    input  wire logic [10:0] break_column_line_in,
    input  wire logic [7:0]  adc_code,
    output logic             adc_track
);
    import kms_pkg::*;

    logic [10:0]  ram_reg [RAM_WORDS];
    logic [10:0]  ram_next [RAM_WORDS];
    logic [NUM_KEYS-1:0] down_reg;
    logic [NUM_KEYS-1:0] down_next;
    logic [1:0]   cfg_reg;
    logic [1:0]   cfg_next;
    logic [6:0]   ptr_reg;
    logic [6:0]   ptr_next;
    logic [7:0]   rdata_reg;
    logic [7:0]   rdata_next;
    logic [8:0]   slot_reg;
    logic [8:0]   slot_next;
    logic [3:0]   row_reg;
    logic [3:0]   row_next;
    kms_phase_t   phase_reg;
    kms_phase_t   phase_next;
    logic [10:0]  mk_reg;
    logic [10:0]  mk_next;
    logic         track_reg;
    logic         track_next;

    logic         key_sample;
    logic         sw_sample;
    logic         adc_sample;
    logic         spring;
    logic         cathode;
    logic         req_any;
    logic [6:0]   req_key;
    logic [6:0]   rd_addr;
    logic [6:0]   led_addr;
    logic [6:0]   sw_addr;
    logic [6:0]   adc_addr;
    logic [10:0]  key_new [NUM_COLS];
    logic         key_wr [NUM_COLS];
    logic         key_dn [NUM_COLS];

    assign spring    = cfg_reg[CFG_SPRING_BIT]; // R02
    assign cathode   = cfg_reg[CFG_CATH_BIT]; // R03
    assign led_addr  = LED_BASE | {4'h0, row_reg[2:0]}; // R06
    assign sw_addr   = SW_BASE | {3'h0, row_reg}; // R06
    assign adc_addr  = ADC_BASE | {3'h0, row_reg}; // R06
    assign key_sample = (phase_reg == PH_KEYS) && (slot_reg == KEY_SAMPLE_AT - 9'h001);
    assign sw_sample  = (phase_reg == PH_IO) && (slot_reg == SW_SAMPLE_AT - 9'h001);
    assign adc_sample = (slot_reg == ADC_HOLD_AT - 9'h001);

    // Row slot sequencer: every slot starts with the keyboard phase.
    always_comb begin
        slot_next = slot_reg + 9'h001;
        row_next  = row_reg;
        if (slot_reg == ROW_SLOT_CYC - 9'h001) begin
            slot_next = 9'h000;
            if (row3_used) begin
                row_next = row_reg + 4'h1; // R11
            end else begin
                row_next = {1'b0, row_reg[2:0] + 3'h1}; // R11
            end
        end
        phase_next = (slot_next < KBD_PHASE_CYC) ? PH_KEYS : PH_IO; // R22
        track_next = (slot_next >= ADC_TRACK_AT) && (slot_next < ADC_HOLD_AT);
        unique case (phase_next)
            PH_KEYS: mk_next = 11'h000;
            PH_IO:   mk_next = ram_reg[led_addr]; // R18
        endcase
    end

    // Per-column key velocity measurement for the current row.
    for (genvar c = 0; c < NUM_COLS; c++) begin : g_col
        logic [6:0]  kaddr;
        logic        first_c;
        logic        second_c;
        logic [10:0] e;
        assign kaddr    = {4'(c), row_reg[2:0]}; // R10
        assign first_c  = break_column_line_in[c] ^ cathode; // R23
        assign second_c = make_column_line_in[c] ^ cathode; // R23
        assign e        = ram_reg[kaddr];
        always_comb begin
            key_new[c] = e;
            key_wr[c]  = 1'b0;
            key_dn[c]  = down_reg[kaddr];
            // An unserviced result is held until the processor acknowledges it.
            if (key_sample && !e[SRQ_BIT]) begin
                key_wr[c] = 1'b1;
                if (!e[BUSY_BIT]) begin
                    key_wr[c] = 1'b0;
                    if (!down_reg[kaddr] && first_c) begin
                        key_new[c] = {1'b0, 1'b1, 1'b1, TIME_ZERO}; // R24
                        key_wr[c]  = 1'b1;
                    end else if (down_reg[kaddr] && !second_c) begin
                        key_new[c] = {1'b0, 1'b0, 1'b1, TIME_ZERO}; // R24
                        key_wr[c]  = 1'b1;
                    end
                end else if (e[ON_BIT]) begin
                    if (second_c) begin
                        key_new[c] = {1'b1, 1'b1, 1'b0, e[7:0]}; // R14
                        key_dn[c]  = 1'b1;
                    end else if (!first_c && !spring) begin
                        key_new[c][BUSY_BIT] = 1'b0;
                    end else if (e[7:0] != TIME_MAX) begin
                        key_new[c][7:0] = e[7:0] + 8'h01; // R17
                    end
                end else begin
                    if (!first_c) begin
                        key_new[c] = {1'b1, 1'b0, 1'b0, e[7:0]}; // R21
                        key_dn[c]  = 1'b0;
                    end else if (second_c && !spring) begin
                        key_new[c][BUSY_BIT] = 1'b0;
                    end else if (e[7:0] != TIME_MAX) begin
                        key_new[c][7:0] = e[7:0] + 8'h01; // R17
                    end
                end
            end
        end
        a_time_saturate: assert property (@(posedge core_clk) disable iff (rst) // R17
            key_wr[c] && e[BUSY_BIT] && key_new[c][BUSY_BIT] && (e[7:0] == TIME_MAX)
            |-> key_new[c][7:0] == TIME_MAX)
            else $error("Key time field wrapped past its maximum.");
        a_srq_not_busy: assert property (@(posedge core_clk) disable iff (rst) // R14
            key_wr[c] && key_new[c][SRQ_BIT] |=> !ram_reg[$past(kaddr)][BUSY_BIT]
            && (ram_reg[$past(kaddr)][ON_BIT] == down_reg[$past(kaddr)])) // R15
            else $error("Completed key entry still marked busy or wrong direction.");
    end

    // Lowest numbered key holding a service request.
    always_comb begin
        req_any = 1'b0;
        req_key = 7'h00;
        for (int k = NUM_KEYS - 1; k >= 0; k--) begin
            if (ram_reg[k][SRQ_BIT]) begin
                req_any = 1'b1; // R07
                req_key = 7'(k); // R08
            end
        end
    end

    // Switch and converter reads alias when the fourth row is absent.
    always_comb begin
        rd_addr = ptr_reg;
        if (!row3_used && (ptr_reg >= SW_BASE)) begin
            rd_addr = {ptr_reg[6:4], 1'b0, ptr_reg[2:0]}; // R12
        end
    end

    // Processor port, then scanner writes; scanner goes last so a set beats a clear.
    always_comb begin
        ram_next   = ram_reg;
        down_next  = down_reg;
        cfg_next   = cfg_reg;
        ptr_next   = ptr_reg;
        rdata_next = rdata_reg;
        if (io_wr) begin
            unique case (io_addr)
                ADDR_SETUP:  cfg_next = io_wdata[1:0]; // R01
                ADDR_STATUS: ptr_next = io_wdata[6:0]; // R09
                ADDR_DLOW:   ram_next[ptr_reg][7:0] = io_wdata; // R13
                ADDR_DHIGH: begin
                    ram_next[ptr_reg][10:8] = io_wdata[2:0]; // R13
                    if (ptr_reg <= KEY_LAST) begin
                        ram_next[ptr_reg][SRQ_BIT] = 1'b0; // R07
                    end
                end
                default: ;
            endcase
        end
        if (io_rd) begin
            unique case (io_addr)
                ADDR_STATUS: rdata_next = {req_any, req_key}; // R05
                ADDR_DLOW:   rdata_next = ram_reg[rd_addr][7:0]; // R13
                ADDR_DHIGH:  rdata_next = {5'h00, ram_reg[rd_addr][10:8]}; // R13
                default:     rdata_next = 8'h00; // R01
            endcase
        end
        for (int c = 0; c < NUM_COLS; c++) begin
            if (key_wr[c]) begin
                ram_next[{4'(c), row_reg[2:0]}] = key_new[c]; // R16
                down_next[{4'(c), row_reg[2:0]}] = key_dn[c];
            end
        end
        if (sw_sample) begin
            ram_next[sw_addr] = break_column_line_in; // R19
        end
        if (adc_sample) begin
            ram_next[adc_addr] = {3'h0, adc_code}; // R20
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < RAM_WORDS; i++) begin
                ram_reg[i] <= 11'h000;
            end
            down_reg  <= '0;
            cfg_reg   <= CFG_RESET; // R04
            ptr_reg   <= 7'h00;
            rdata_reg <= 8'h00;
            slot_reg  <= 9'h000;
            row_reg   <= 4'h0;
            phase_reg <= PH_KEYS;
            mk_reg    <= 11'h000;
            track_reg <= 1'b0;
        end else begin
            ram_reg   <= ram_next;
            down_reg  <= down_next;
            cfg_reg   <= cfg_next;
            ptr_reg   <= ptr_next;
            rdata_reg <= rdata_next;
            slot_reg  <= slot_next;
            row_reg   <= row_next;
            phase_reg <= phase_next;
            mk_reg    <= mk_next;
            track_reg <= track_next;
        end
    end

    assign io_rdata             = rdata_reg;
    assign row_sel              = row_reg[2:0];
    assign row3_out             = row_reg[3];
    assign scan_phase_strobe    = (phase_reg == PH_KEYS); // R22
    assign make_column_line_out = mk_reg;
    assign make_column_line_oe  = (phase_reg == PH_IO); // R18
    assign adc_track            = track_reg;

    a_strobe_rise: assert property (@(posedge core_clk) disable iff (rst) // R22
        $rose(scan_phase_strobe) |-> (slot_reg == 9'h000) && $past(slot_reg) == ROW_SLOT_CYC - 9'h001)
        else $error("Keyboard phase did not start at the row boundary.");
    a_strobe_fall: assert property (@(posedge core_clk) disable iff (rst) // R22
        $fell(scan_phase_strobe) |-> slot_reg == KBD_PHASE_CYC)
        else $error("Keyboard phase length is wrong.");
    a_row_step: assert property (@(posedge core_clk) disable iff (rst) // R11
        $changed(row_sel) |-> (row_sel == $past(row_sel) + 3'h1) && (slot_reg == 9'h000))
        else $error("Row select stepped out of order or off the slot boundary.");
    a_setup_load: assert property (@(posedge core_clk) disable iff (rst) // R01
        io_wr && (io_addr == ADDR_SETUP) |=> cfg_reg == $past(io_wdata[1:0]))
        else $error("Setup register did not take the written value.");
    a_ptr_load: assert property (@(posedge core_clk) disable iff (rst) // R09
        io_wr && (io_addr == ADDR_STATUS) |=> ptr_reg == $past(io_wdata[6:0]))
        else $error("RAM pointer did not load from the status write.");
    a_status_read: assert property (@(posedge core_clk) disable iff (rst) // R07
        io_rd && (io_addr == ADDR_STATUS) |=> io_rdata == {$past(req_any), $past(req_key)})
        else $error("Status read does not show the pending request.");
    a_led_drive: assert property (@(posedge core_clk) disable iff (rst) // R18
        !scan_phase_strobe && $past(!scan_phase_strobe) && $stable(row_sel)
        |-> make_column_line_oe && make_column_line_out == $past(ram_reg[led_addr]))
        else $error("Make lines do not show the row's LED entry.");
    a_switch_capture: assert property (@(posedge core_clk) disable iff (rst) // R19
        sw_sample && !(io_wr && (io_addr == ADDR_DLOW || io_addr == ADDR_DHIGH))
        |=> ram_reg[$past(sw_addr)] == $past(break_column_line_in))
        else $error("Switch entry did not capture the break lines.");
    a_adc_capture: assert property (@(posedge core_clk) disable iff (rst) // R20
        adc_sample |=> ram_reg[$past(adc_addr)] == {3'h0, $past(adc_code)})
        else $error("Converter entry did not capture the sampled code.");
    a_track_window: assert property (@(posedge core_clk) disable iff (rst) // R20
        adc_track |-> (slot_reg >= ADC_TRACK_AT) && (slot_reg < ADC_HOLD_AT))
        else $error("Converter tracks outside its window in the row slot.");
endmodule

// *** kms_kbd_model.sv ***
// Far-side model: one velocity key, a switch bank and the converter input.
module kms_kbd_model (
    input  wire logic [2:0]  row_sel,
    input  wire logic        strobe,
    input  wire logic [10:0] led,
    input  wire logic        led_oe,
    input  wire logic [3:0]  key_col,
    input  wire logic [2:0]  key_row,
    input  wire logic        first_on,
    input  wire logic        second_on,
    input  wire logic [10:0] sw_pat,
    output logic      [10:0] mk_in,
    output logic      [10:0] br_in,
    output logic      [7:0]  adc
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] key_bit;
    always_comb begin
        key_bit = (row_sel == key_row) ? (11'h001 << key_col) : 11'h000;
        if (strobe) begin
            br_in = first_on ? key_bit : 11'h000;
            mk_in = second_on ? key_bit : 11'h000;
        end else begin
            // Switch data differs per row, so a capture into the wrong entry shows.
            br_in = sw_pat ^ {8'h00, row_sel};
            mk_in = led_oe ? led : ~led;
        end
        adc = {row_sel, 5'h15};
    end
endmodule

// *** test_keyboard_matrix_scanner.sv ***
// Self-checking bench of the keyboard matrix scanner.
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %0h got %0h", n, e, a); end end
module test_keyboard_matrix_scanner;
    timeunit 1ns;
    timeprecision 1ns;
    import kms_pkg::*;
    logic        core_clk;
    logic        rst;
    logic [3:0]  io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic [2:0]  row_sel;
    logic        strobe;
    logic [10:0] mk_out;
    logic        mk_oe;
    logic [10:0] mk_in;
    logic [10:0] br_in;
    logic [7:0]  adc;
    logic        first_on;
    logic        second_on;
    logic        row3_used;
    logic        row3_out;
    logic        adc_track;
    int          error_cnt;
    int          n_compared;
    int          cyc;

    kms_scanner uut (.core_clk(core_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .row3_used(row3_used),
        .row_sel(row_sel), .row3_out(row3_out), .scan_phase_strobe(strobe),
        .make_column_line_out(mk_out), .make_column_line_oe(mk_oe),
        .make_column_line_in(mk_in), .break_column_line_in(br_in), .adc_code(adc),
        .adc_track(adc_track));
    kms_kbd_model far (.row_sel(row_sel), .strobe(strobe), .led(mk_out), .led_oe(mk_oe),
        .key_col(4'd5), .key_row(3'd3), .first_on(first_on), .second_on(second_on),
        .sw_pat(11'h5c3), .mk_in(mk_in), .br_in(br_in), .adc(adc));

    always #10 core_clk = ~core_clk;

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A hang must still end in the closing report.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            give_verdict;
        end
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        io_addr <= a;
        io_wdata <= v;
        io_wr <= 1'b1;
        @(posedge core_clk);
        io_wr <= 1'b0;
    endtask

    task automatic rc(input logic [3:0] a, input logic [7:0] e, input string n);
        @(posedge core_clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge core_clk);
        io_rd <= 1'b0;
        #1;
        `CHK(n, e, io_rdata)
    endtask

    task automatic leave(input logic [2:0] r);
        while (row_sel !== r) @(posedge core_clk);
        while (row_sel === r) @(posedge core_clk);
    endtask

    task automatic t_reset;
        rc(ADDR_SETUP, 8'h00, "setup read");
        rc(ADDR_STATUS, 8'h00, "idle status");
        rc(4'h3, 8'h00, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_timing;
        int n;
        logic [2:0] r;
        while (strobe !== 1'b0) @(posedge core_clk);
        while (strobe !== 1'b1) @(posedge core_clk);
        r = row_sel;
        n = 0;
        while (strobe === 1'b1) begin
            n++;
            @(posedge core_clk);
        end
        `CHK("key phase", 70, n)
        n = 0;
        while (strobe === 1'b0) begin
            n++;
            @(posedge core_clk);
        end
        `CHK("io phase", 215, n)
        `CHK("row step", r + 3'd1, row_sel)
        while (adc_track !== 1'b1) @(posedge core_clk);
        n = 0;
        while (adc_track === 1'b1) begin
            n++;
            @(posedge core_clk);
        end
        `CHK("track time", 60, n)
        $display("test timing done");
    endtask

    task automatic t_led;
        wr(ADDR_STATUS, 8'hd8);
        wr(ADDR_DLOW, 8'ha5);
        wr(ADDR_DHIGH, 8'hff);
        rc(ADDR_DHIGH, 8'h07, "led high");
        rc(ADDR_DLOW, 8'ha5, "led low");
        while (!(row_sel === 3'd0 && mk_oe === 1'b1)) @(posedge core_clk);
        `CHK("led lines", 11'h7a5, mk_out)
        $display("test led done");
    endtask

    task automatic t_switch;
        leave(3'd7);
        wr(ADDR_STATUS, 8'h62);
        rc(ADDR_DLOW, 8'hc1, "switch low");
        rc(ADDR_DHIGH, 8'h05, "switch high");
        wr(ADDR_STATUS, 8'h6a);
        rc(ADDR_DLOW, 8'hc1, "switch alias");
        wr(ADDR_STATUS, 8'h73);
        rc(ADDR_DLOW, 8'h75, "converter");
        wr(ADDR_STATUS, 8'h7b);
        rc(ADDR_DLOW, 8'h75, "converter alias");
        $display("test switch done");
    endtask

    task automatic t_press;
        leave(3'd3);
        first_on <= 1'b1;
        leave(3'd3);
        wr(ADDR_STATUS, 8'h2b);
        rc(ADDR_DHIGH, 8'h03, "busy flags");
        rc(ADDR_DLOW, 8'h00, "start time");
        // Preloading the count one below its top lets the first of the next two visits reach saturation and the second hold it.
        wr(ADDR_DLOW, 8'hfe);
        leave(3'd3);
        leave(3'd3);
        second_on <= 1'b1;
        leave(3'd3);
        rc(ADDR_STATUS, 8'hab, "press status");
        rc(ADDR_DHIGH, 8'h06, "press flags");
        rc(ADDR_DLOW, 8'hff, "press time");
        wr(ADDR_DHIGH, 8'h00);
        rc(ADDR_STATUS, 8'h00, "ack status");
        $display("test press done");
    endtask

    task automatic t_release;
        @(posedge core_clk);
        second_on <= 1'b0;
        leave(3'd3);
        rc(ADDR_DHIGH, 8'h01, "release busy");
        @(posedge core_clk);
        first_on <= 1'b0;
        leave(3'd3);
        rc(ADDR_STATUS, 8'hab, "release status");
        rc(ADDR_DHIGH, 8'h04, "release flags");
        rc(ADDR_DLOW, 8'h00, "release time");
        $display("test release done");
    endtask

    task automatic t_fourth_row;
        @(posedge core_clk);
        row3_used <= 1'b1;
        wr(ADDR_STATUS, 8'h6a);
        rc(ADDR_DLOW, 8'h00, "no alias");
        while (row3_out !== 1'b1) @(posedge core_clk);
        `CHK("row eight", 3'd0, row_sel)
        $display("test fourth row done");
    endtask

    // Inverted wiring turns idle lines into closed contacts, so every key without a pending request reports a press.
    task automatic t_wiring;
        wr(ADDR_SETUP, 8'h03);
        rc(ADDR_SETUP, 8'h00, "setup write-only");
        leave(3'd0);
        leave(3'd0);
        leave(3'd0);
        rc(ADDR_STATUS, 8'h80, "inverted status");
        wr(ADDR_STATUS, 8'h00);
        rc(ADDR_DHIGH, 8'h06, "inverted press");
        $display("test wiring done");
    endtask

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        io_addr = 4'h0;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
        first_on = 1'b0;
        second_on = 1'b0;
        row3_used = 1'b0;
        error_cnt = 0;
        n_compared = 0;
        cyc = 0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        t_reset;
        t_timing;
        t_led;
        t_switch;
        t_press;
        t_release;
        t_fourth_row;
        t_wiring;
        give_verdict;
    end
endmodule
